/* hdl/msr_pkg.sv */
// package for the motor status and telemetry register group
package msr_pkg;

  // register offsets on the host register port
  localparam logic [7:0] MSR_ADDR_FAULT = 8'h00;
  localparam logic [7:0] MSR_ADDR_SPEED = 8'h01;
  localparam logic [7:0] MSR_ADDR_PERIOD = 8'h02;
  localparam logic [7:0] MSR_ADDR_KT = 8'h03;
  localparam logic [7:0] MSR_ADDR_CURRENT = 8'h04;

  // widths
  localparam int MSR_ADDR_W = 8;
  localparam int MSR_DATA_W = 16;
  localparam int MSR_CURRENT_W = 11;
  localparam int MSR_LOCK_COUNT = 6;

  // fault register field positions (lock flags)
  localparam int MSR_BIT_HW_CURRENT_LIMIT = 0;
  localparam int MSR_BIT_SPEED_ABNORMAL = 1;
  localparam int MSR_BIT_BEMF_CONST_ABNORMAL = 2;
  localparam int MSR_BIT_NO_MOTOR = 3;
  localparam int MSR_BIT_OPEN_LOOP_STUCK = 4;
  localparam int MSR_BIT_CLOSED_LOOP_STUCK = 5;

  // reset values
  localparam logic [15:0] MSR_RESET_READING = 16'h0000;
  localparam logic [10:0] MSR_RESET_CURRENT = 11'h000;
  localparam logic [15:0] MSR_READ_UNMAPPED = 16'h0000;

  // measurement set written by the measurement engine
  typedef struct packed {
    logic [15:0] rotation_rate;
    logic [15:0] electrical_period;
    logic [15:0] bemf_constant;
    logic [10:0] phase_current;
  } msr_meas_type;

  // host register port request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } msr_req_type;

endpackage

/* hdl/msr_flag_cell.sv */
// one sticky fault flag, set by hardware, cleared by writing one
module msr_flag_cell (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // hardware event and software clear
  input wire logic set_pulse,
  input wire logic clr_pulse,
  // flag state
  output logic flag
);

  logic flag_reg;
  logic flag_next;

  // set beats clear so an event in the clear cycle is not lost
  always_comb begin
    flag_next = flag_reg;
    if (set_pulse) begin
      flag_next = 1'b1;
    end else if (clr_pulse) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

endmodule

/* hdl/msr_telemetry_regs.sv */
// motor status and telemetry register group: lock flags and measurements
// Operation
// - six lock flags in fault bits 5:0, reset to 0, cleared by writing 1
// - read-only 16-bit rotation rate at 0x01, hertz is value over 10
// - read-only 16-bit period at 0x02, microseconds is value times 10
// - read-only 16-bit back-EMF constant at 0x03, value over 2 over 1090
// - read-only 11-bit phase current in bits 10:0 at 0x04
// - current register bits 15:11 read as zero; software leaves them alone
module msr_telemetry_regs
  import msr_pkg::*;
#(
  parameter int LOCK_COUNT = MSR_LOCK_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host register port
  input wire msr_req_type req,
  output logic [15:0] rdata,
  output logic rvalid,
  // measurement engine side
  input wire logic meas_valid,
  input wire msr_meas_type meas,
  input wire logic [LOCK_COUNT-1:0] lock_event,
  // summary status
  output logic fault_any
);

  // the flag layout is fixed by the fault register
  if (LOCK_COUNT != MSR_LOCK_COUNT) begin : g_bad_lock_count
    $error("msr_telemetry_regs: LOCK_COUNT must be 6");
  end

  logic [LOCK_COUNT-1:0] flags;
  logic [LOCK_COUNT-1:0] clr_vec;
  msr_meas_type meas_reg;
  msr_meas_type meas_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic fault_any_reg;
  logic fault_any_next;
  logic fault_wr;

  assign fault_wr = req.wr && (req.addr == MSR_ADDR_FAULT);
  assign clr_vec = fault_wr ? req.wdata[LOCK_COUNT-1:0] : '0;

  for (genvar i = 0; i < LOCK_COUNT; i++) begin : g_flag
    msr_flag_cell u_flag (
      .clk(clk),
      .resetn(resetn),
      .set_pulse(lock_event[i]),
      .clr_pulse(clr_vec[i]),
      .flag(flags[i])
    );
  end

  // measurement capture; host writes to these offsets are ignored
  always_comb begin
    meas_next = meas_reg;
    if (meas_valid) begin
      meas_next = meas;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meas_reg.rotation_rate <= MSR_RESET_READING;
      meas_reg.electrical_period <= MSR_RESET_READING;
      meas_reg.bemf_constant <= MSR_RESET_READING;
      meas_reg.phase_current <= MSR_RESET_CURRENT;
    end else begin
      meas_reg <= meas_next;
    end
  end

  // read mux; data appears the cycle after the read strobe
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = req.rd;
    if (req.rd) begin
      if (req.addr == MSR_ADDR_FAULT) begin
        // flags in low bits, others zero
        rdata_next = {{(MSR_DATA_W - LOCK_COUNT){1'b0}}, flags};
      end else if (req.addr == MSR_ADDR_SPEED) begin
        rdata_next = meas_reg.rotation_rate;
      end else if (req.addr == MSR_ADDR_PERIOD) begin
        rdata_next = meas_reg.electrical_period;
      end else if (req.addr == MSR_ADDR_KT) begin
        rdata_next = meas_reg.bemf_constant;
      end else if (req.addr == MSR_ADDR_CURRENT) begin
        rdata_next = {{(MSR_DATA_W - MSR_CURRENT_W){1'b0}}, meas_reg.phase_current};
      end else begin
        rdata_next = MSR_READ_UNMAPPED;
      end
    end
  end

  // summary is one cycle behind the flags so it comes from a flop
  always_comb begin
    fault_any_next = |flags;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      fault_any_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      fault_any_reg <= fault_any_next;
    end
  end

  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;
  assign fault_any = fault_any_reg;

  // checks
  property p_flag_clear;
    @(posedge clk) disable iff (!resetn)
    (fault_wr && req.wdata[0] && !lock_event[0]) |=> (flags[0] == 1'b0);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_set;
    @(posedge clk) disable iff (!resetn)
    lock_event[5] |=> flags[5] ##1 (flags[5] || $past(clr_vec[5]));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag did not set");

  property p_flag_sticky;
    @(posedge clk) disable iff (!resetn)
    (flags[3] && !clr_vec[3]) |=> flags[3];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_speed_read;
    @(posedge clk) disable iff (!resetn)
    (req.rd && req.addr == MSR_ADDR_SPEED) |=>
      (rvalid && rdata == $past(meas_reg.rotation_rate));
  endproperty
  a_speed_read: assert property (p_speed_read) else $error("speed readback wrong");

  property p_period_read;
    @(posedge clk) disable iff (!resetn)
    (meas_valid ##1 (req.rd && req.addr == MSR_ADDR_PERIOD && !meas_valid)) |=>
      (rdata == $past(meas.electrical_period, 2));
  endproperty
  a_period_read: assert property (p_period_read) else $error("period readback wrong");

  property p_kt_read;
    @(posedge clk) disable iff (!resetn)
    (meas_valid ##1 (req.rd && req.addr == MSR_ADDR_KT && !meas_valid)) |=>
      (rdata == $past(meas.bemf_constant, 2));
  endproperty
  a_kt_read: assert property (p_kt_read) else $error("constant readback wrong");

  property p_current_read;
    @(posedge clk) disable iff (!resetn)
    (meas_valid ##1 (req.rd && req.addr == MSR_ADDR_CURRENT && !meas_valid)) |=>
      (rdata[10:0] == $past(meas.phase_current, 2));
  endproperty
  a_current_read: assert property (p_current_read) else $error("current readback wrong");

  property p_current_reserved;
    @(posedge clk) disable iff (!resetn)
    (req.rd && req.addr == MSR_ADDR_CURRENT) |=> (rvalid && rdata[15:11] == 5'h00);
  endproperty
  a_current_reserved: assert property (p_current_reserved) else $error("reserved bits set");

  property p_fault_read;
    @(posedge clk) disable iff (!resetn)
    (req.rd && req.addr == MSR_ADDR_FAULT) |=>
      (rvalid && rdata[LOCK_COUNT-1:0] == $past(flags) && rdata[MSR_DATA_W-1:LOCK_COUNT] == '0);
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault readback wrong");

  // host writes never reach the readings; only a capture moves them
  property p_reading_hold;
    @(posedge clk) disable iff (!resetn)
    !meas_valid |=> $stable(meas_reg);
  endproperty
  a_reading_hold: assert property (p_reading_hold) else $error("reading moved");

  property p_zero_write_keeps;
    @(posedge clk) disable iff (!resetn)
    (fault_wr && !req.wdata[1] && flags[1]) |=> flags[1];
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write cleared");

  property p_set_wins;
    @(posedge clk) disable iff (!resetn)
    (lock_event[2] && clr_vec[2]) |=> flags[2];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

  // answer strobe must track the read strobe exactly one edge later
  property p_rvalid_pulse;
    @(posedge clk) disable iff (!resetn)
    rvalid == $past(req.rd);
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer out of step");

  property p_fault_any;
    @(posedge clk) disable iff (!resetn)
    fault_any == |$past(flags);
  endproperty
  a_fault_any: assert property (p_fault_any) else $error("fault summary out of step");

  c_flag_cleared: cover property (@(posedge clk) disable iff (!resetn) flags[0] ##1 !flags[0]);
  c_set_wins: cover property (@(posedge clk) disable iff (!resetn) lock_event[2] && clr_vec[2]);
  c_current_read: cover property (@(posedge clk) disable iff (!resetn)
    req.rd && req.addr == MSR_ADDR_CURRENT);
  c_capture_read: cover property (@(posedge clk) disable iff (!resetn)
    meas_valid ##1 (req.rd && req.addr == MSR_ADDR_PERIOD));
  c_summary_rise: cover property (@(posedge clk) disable iff (!resetn)
    !fault_any ##1 fault_any);

endmodule

/* sim/tb.sv */
// self-checking bench for the motor status and telemetry registers
module tb
  import msr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, resetn, meas_valid, rvalid, fault_any;
  logic [15:0] rdata, got;
  logic [5:0] lock_event;
  msr_req_type req;
  msr_meas_type meas;
  int n_mismatch, num_checks;

  // unit under test
  msr_telemetry_regs u_msr_telemetry_regs (
    .clk(clk),
    .resetn(resetn),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .meas_valid(meas_valid),
    .meas(meas),
    .lock_event(lock_event),
    .fault_any(fault_any)
  );

  // 20 mhz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // compare one 16-bit result
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // read strobe; answer is due exactly one edge later
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    req.addr = a;
    req.rd = 1'b1;
    @(posedge clk);
    #1 req.rd = 1'b0;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    d = rdata;
    @(posedge clk);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    rd(a, got);
    chk($sformatf("reg %h", a), exp, got);
  endtask

  // write strobe, then one more edge so fault_any has caught up
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(posedge clk);
    #1 req.wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // everything reads zero after reset, unmapped too
  task automatic t_reset();
    for (int a = 0; a < 5; a++) rdchk(a[7:0], 16'h0000);
    rdchk(8'h07, MSR_READ_UNMAPPED);
    chk("fault_any", 16'h0000, {15'h0000, fault_any});
  endtask

  // one capture pulse; the inputs are cleared straight after it
  task automatic cap(input msr_meas_type m);
    meas = m;
    meas_valid = 1'b1;
    @(posedge clk);
    #1 meas_valid = 1'b0;
    meas = '0;
  endtask

  // read right after a capture, then capture holds; writes to readings ignored
  task automatic t_capture();
    cap({16'h1111, 16'habcd, 16'h2222, 11'h333});
    rdchk(MSR_ADDR_PERIOD, 16'habcd);
    cap({16'h4444, 16'h5555, 16'h8001, 11'h666});
    rdchk(MSR_ADDR_KT, 16'h8001);
    cap({16'h1234, 16'h0777, 16'h0888, 11'h7ff});
    rdchk(MSR_ADDR_CURRENT, 16'h07ff);
    for (int a = 1; a < 4; a++) wr(a[7:0], 16'h5a5a);
    wr(MSR_ADDR_CURRENT, 16'h05a5);
    rdchk(MSR_ADDR_SPEED, 16'h1234);
    rdchk(MSR_ADDR_PERIOD, 16'h0777);
    rdchk(MSR_ADDR_KT, 16'h0888);
    rdchk(MSR_ADDR_CURRENT, 16'h07ff);
  endtask

  // each flag: sticky, deaf to zeros and other ones, cleared by its one
  task automatic t_flags();
    logic [15:0] m;
    for (int b = 0; b < MSR_LOCK_COUNT; b++) begin
      m = 16'h0001 << b;
      lock_event = m[5:0];
      @(posedge clk);
      #1 lock_event = 6'h00;
      wr(MSR_ADDR_FAULT, 16'h0000);
      wr(MSR_ADDR_FAULT, ~m);
      rdchk(MSR_ADDR_FAULT, m);
      chk("fault_any", 16'h0001, {15'h0000, fault_any});
      wr(MSR_ADDR_FAULT, m);
      rdchk(MSR_ADDR_FAULT, 16'h0000);
      chk("fault_any", 16'h0000, {15'h0000, fault_any});
    end
    // set wins over a clear in the same cycle; event held for that edge only
    lock_event = 6'h3f;
    req.addr = MSR_ADDR_FAULT;
    req.wdata = 16'h003f;
    req.wr = 1'b1;
    @(posedge clk);
    #1 lock_event = 6'h00;
    req.wr = 1'b0;
    rdchk(MSR_ADDR_FAULT, 16'h003f);
    chk("fault_any", 16'h0001, {15'h0000, fault_any});
    // reset in mid-run clears flags
    resetn = 1'b0;
    @(posedge clk);
    #1 resetn = 1'b1;
    rdchk(MSR_ADDR_FAULT, 16'h0000);
    chk("fault_any", 16'h0000, {15'h0000, fault_any});
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  // main sequence
  initial begin
    req = '0;
    meas = '0;
    meas_valid = 1'b0;
    lock_event = 6'h00;
    resetn = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    t_reset();
    t_capture();
    t_flags();
    close_out();
  end
endmodule
